// ==== design/acb_clk_if.sv ====
// Purpose: Carries one analog clock selection between modules
// Assumes: Codes follow the eight-entry block table
// Notes:   Range bit picks the digital block bank
`timescale 1ns/1ps
interface acb_clk_if;
  logic [2:0] code;
  logic       range;
  logic [7:0] blocks_lo;
  logic [7:0] blocks_hi;
  logic       clk_out;
  modport ctrl (output code, output range, output blocks_lo, output blocks_hi, input clk_out);
  modport sel  (input code, input range, input blocks_lo, input blocks_hi, output clk_out);
endinterface : acb_clk_if

// ==== design/acb_clk_sel.sv ====
// Purpose: Registered eight-way digital block output selector
// Assumes: Block outputs synchronous to pclk
// Notes:   Index = code: 0 basic 00, 1 basic 01, 2 comm 02, 3 comm 03,
//          4 basic 10, 5 basic 11, 6 comm 12, 7 comm 13
`timescale 1ns/1ps
module acb_clk_sel (
  input  wire logic pclk,
  input  wire logic presetn,
  acb_clk_if.sel    sel_if
);
  import acb_pkg::*;

  logic [ACB_NUM_BLOCKS-1:0] bank;

  // Range bit picks which block bank the code indexes
  assign bank = sel_if.range ? sel_if.blocks_hi : sel_if.blocks_lo;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_if.clk_out <= 1'b0;
    end else begin
      sel_if.clk_out <= bank[sel_if.code];
    end
  end
endmodule : acb_clk_sel

// ==== design/acb_ctrl.sv ====
// Purpose: APB register bank for analog clock sources and output buffers
// Assumes: Variant strap is static; APB answers with no wait state
// Notes:   Unmapped addresses read zero, ignore writes, no error
`timescale 1ns/1ps
// Operation
// - Clock source reg: sample-hold off bit 6, clock b 5:3, clock a 2:0.
// - Clock b selector routes chosen digital block output, eight codes.
// - Codes 0..3 pick basic 00, basic 01, comm 02, comm 03.
// - Codes 4..7 pick basic 10, 11, comm 12, 13; reserved on smallest.
// - A range bit per clock picks which digital block bank codes refer to.
// - Limited two-column variant: no sample-hold, selectors 4:3 and 1:0.
// - Bit 7: column 1 input from column 1 mux at 0, column 0 at 1.
// - One-column variant: bit 7 picks even pins at 0, odd at 1.
// - Bit 6: column 2 input from column 2 mux at 0, column 3 at 1.
// - Bit 5 enables column 1 output buffer on port 0 pin 5.
// - Bit 4 enables column 2 output buffer on port 0 pin 4.
// - Bit 3 enables column 0 buffer on pin 3; analog ground on one column (one-column mask drops bit 3, so ground stays off).
// - Implemented bits per variant; others reserved.
// - Bit 2 enables column 3 output buffer on port 0 pin 2.
// - Bit 1 bypasses amplifiers; software keeps them disabled meanwhile.
// - Bit 0 sets power level of all output buffers, 1 is high.
module acb_ctrl (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire acb_pkg::acb_variant_type variant,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     clock_a_block_range,
  input  wire logic                     clock_b_block_range,
  input  wire logic [7:0]               blocks_lo,
  input  wire logic [7:0]               blocks_hi,
  output logic                          analog_clock_a,
  output logic                          analog_clock_b,
  output logic                          sample_hold_off,
  output logic                          column_one_input_steer,
  output logic                          column_two_input_steer,
  output logic                          col0_out_buffer_on,
  output logic                          col1_out_buffer_on,
  output logic                          col2_out_buffer_on,
  output logic                          col3_out_buffer_on,
  output logic                          col0_drives_analog_ground,
  output logic                          col1_odd_pin_group,
  output logic                          amp_bypass,
  output logic                          buffer_power_level
);
  import acb_pkg::*;

  logic [7:0]  analog_clock_source_select;
  logic [7:0]  analog_output_buffer_control;
  logic [7:0]  clk_mask;
  logic [7:0]  buf_mask;
  logic [7:0]  next_clk;
  logic [7:0]  next_buf;
  logic [31:0] next_rdata;
  logic        wr_en;
  logic        rd_en;
  logic        hit_clk;
  logic        hit_buf;

  acb_clk_if clk_a_if ();
  acb_clk_if clk_b_if ();

  assign hit_clk = (paddr == ACB_ADDR_CLK_SRC);
  assign hit_buf = (paddr == ACB_ADDR_BUF_CTL);
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;

  // Implemented bits per variant; masked bits never store
  always_comb begin
    case (variant)
      ACB_VAR_FOUR: begin
        clk_mask = ACB_CLK_MASK_FULL;
        buf_mask = ACB_BUF_MASK_FOUR;
      end
      ACB_VAR_TWO: begin
        clk_mask = ACB_CLK_MASK_FULL;
        buf_mask = ACB_BUF_MASK_TWO;
      end
      ACB_VAR_TWO_LM: begin
        clk_mask = ACB_CLK_MASK_LIM;
        buf_mask = ACB_BUF_MASK_LIM;
      end
      ACB_VAR_ONE: begin
        clk_mask = ACB_CLK_MASK_FULL;
        buf_mask = ACB_BUF_MASK_ONE;
      end
      default: begin
        clk_mask = ACB_CLK_MASK_FULL;
        buf_mask = ACB_BUF_MASK_FOUR;
      end
    endcase
  end

  // Masking also guards against software leaving reserved bits set
  assign next_clk = pwdata[7:0] & clk_mask;
  assign next_buf = pwdata[7:0] & buf_mask;

  // Clock source register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_clock_source_select <= ACB_CLK_SRC_RESET;
    end else if (wr_en && hit_clk) begin
      analog_clock_source_select <= next_clk;
    end
  end

  // Buffer control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_output_buffer_control <= ACB_BUF_CTL_RESET;
    end else if (wr_en && hit_buf) begin
      analog_output_buffer_control <= next_buf;
    end
  end

  // Full address compare; aliases of the two words read zero
  always_comb begin
    if (hit_clk) begin
      next_rdata = {24'h00_0000, analog_clock_source_select};
    end else if (hit_buf) begin
      next_rdata = {24'h00_0000, analog_output_buffer_control};
    end else begin
      next_rdata = 32'h0000_0000;
    end
  end

  // Read data registered in setup so it is valid in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= next_rdata;
    end
  end

  // Zero wait states; pready low in reset, high from the first edge after
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
    end
  end

  // No error response exists; unmapped accesses complete quietly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= 1'b0;
    end
  end

  // Selector feeds; limited variant has only two code bits
  always_comb begin
    clk_a_if.code      = analog_clock_source_select[ACB_CLKA_LSB +: 3];
    clk_b_if.code      = analog_clock_source_select[ACB_CLKB_LSB +: 3];
    if (variant == ACB_VAR_TWO_LM) begin
      clk_a_if.code[2] = 1'b0;
      clk_b_if.code[2] = 1'b0;
    end
    clk_a_if.range     = clock_a_block_range;
    clk_b_if.range     = clock_b_block_range;
    clk_a_if.blocks_lo = blocks_lo;
    clk_a_if.blocks_hi = blocks_hi;
    clk_b_if.blocks_lo = blocks_lo;
    clk_b_if.blocks_hi = blocks_hi;
  end

  acb_clk_sel u_sel_a (
    .pclk    (pclk),
    .presetn (presetn),
    .sel_if  (clk_a_if.sel)
  );

  acb_clk_sel u_sel_b (
    .pclk    (pclk),
    .presetn (presetn),
    .sel_if  (clk_b_if.sel)
  );

  // Retimed so every output comes straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_clock_a <= 1'b0;
    end else begin
      analog_clock_a <= clk_a_if.clk_out;
    end
  end

  // Same retime for clock b keeps both clocks at one latency
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_clock_b <= 1'b0;
    end else begin
      analog_clock_b <= clk_b_if.clk_out;
    end
  end

  // Control levels follow the registers one edge later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_hold_off <= 1'b0;
    end else begin
      sample_hold_off <= analog_clock_source_select[ACB_SH_OFF_BIT];
    end
  end

  // Single column: bit 7 steers pin group, not column mux
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      column_one_input_steer <= 1'b0;
    end else begin
      column_one_input_steer <= (variant != ACB_VAR_ONE) &&
                                analog_output_buffer_control[ACB_COL1_STEER_BIT];
    end
  end

  // Held low elsewhere so bit 7 never reaches the pin group mux
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col1_odd_pin_group <= 1'b0;
    end else begin
      col1_odd_pin_group <= (variant == ACB_VAR_ONE) &&
                            analog_output_buffer_control[ACB_COL1_STEER_BIT];
    end
  end

  // Not gated by variant; the mask keeps bit 6 clear where unused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      column_two_input_steer <= 1'b0;
    end else begin
      column_two_input_steer <= analog_output_buffer_control[ACB_COL2_STEER_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col1_out_buffer_on <= 1'b0;
    end else begin
      col1_out_buffer_on <= analog_output_buffer_control[ACB_BUF1_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col2_out_buffer_on <= 1'b0;
    end else begin
      col2_out_buffer_on <= analog_output_buffer_control[ACB_BUF2_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col3_out_buffer_on <= 1'b0;
    end else begin
      col3_out_buffer_on <= analog_output_buffer_control[ACB_BUF3_BIT];
    end
  end

  // Single column reuses bit 3 for analog ground on pin 3
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col0_out_buffer_on <= 1'b0;
    end else begin
      col0_out_buffer_on <= (variant != ACB_VAR_ONE) &&
                            analog_output_buffer_control[ACB_BUF0_BIT];
    end
  end

  // Limitation: the single-column mask drops bit 3, so this stays low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col0_drives_analog_ground <= 1'b0;
    end else begin
      col0_drives_analog_ground <= (variant == ACB_VAR_ONE) &&
                                   analog_output_buffer_control[ACB_BUF0_BIT];
    end
  end

  // Bypass is not gated; amplifier disable is software's job
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_bypass <= 1'b0;
    end else begin
      amp_bypass <= analog_output_buffer_control[ACB_BYPASS_BIT];
    end
  end

  // One level for every buffer; there is no per-column power control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer_power_level <= 1'b0;
    end else begin
      buffer_power_level <= analog_output_buffer_control[ACB_POWER_BIT];
    end
  end

endmodule : acb_ctrl

// ==== design/acb_pkg.sv ====
// Purpose: Constants and types for the analog clock and buffer control block
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   Printed offsets are indices; byte address is four times the index
package acb_pkg;

  // Column-count variants of the register layout
  typedef enum logic [3:0] {
    ACB_VAR_FOUR   = 4'b0001,
    ACB_VAR_TWO    = 4'b0010,
    ACB_VAR_TWO_LM = 4'b0100,
    ACB_VAR_ONE    = 4'b1000
  } acb_variant_type;

  localparam int unsigned ACB_IDX_CLK_SRC = 32'h61;
  localparam int unsigned ACB_IDX_BUF_CTL = 32'h62;
  localparam logic [11:0] ACB_ADDR_CLK_SRC = 12'h184;
  localparam logic [11:0] ACB_ADDR_BUF_CTL = 12'h188;

  localparam logic [7:0] ACB_CLK_SRC_RESET = 8'h00;
  localparam logic [7:0] ACB_BUF_CTL_RESET = 8'h00;

  // Clock source register fields
  localparam int unsigned ACB_SH_OFF_BIT = 6;
  localparam int unsigned ACB_CLKB_LSB   = 3;
  localparam int unsigned ACB_CLKA_LSB   = 0;

  // Buffer control register fields
  localparam int unsigned ACB_COL1_STEER_BIT = 7;
  localparam int unsigned ACB_COL2_STEER_BIT = 6;
  localparam int unsigned ACB_BUF1_BIT       = 5;
  localparam int unsigned ACB_BUF2_BIT       = 4;
  localparam int unsigned ACB_BUF0_BIT       = 3;
  localparam int unsigned ACB_BUF3_BIT       = 2;
  localparam int unsigned ACB_BYPASS_BIT     = 1;
  localparam int unsigned ACB_POWER_BIT      = 0;

  // Writable masks per variant
  localparam logic [7:0] ACB_CLK_MASK_FULL = 8'h7f;
  localparam logic [7:0] ACB_CLK_MASK_LIM  = 8'h1b;
  localparam logic [7:0] ACB_BUF_MASK_FOUR = 8'hff;
  localparam logic [7:0] ACB_BUF_MASK_TWO  = 8'hab;
  localparam logic [7:0] ACB_BUF_MASK_LIM  = 8'h80;
  localparam logic [7:0] ACB_BUF_MASK_ONE  = 8'ha3;

  localparam int unsigned ACB_NUM_BLOCKS = 8;

endpackage : acb_pkg

// ==== tb/acb_ctrl_chk.sv ====
// Purpose: Port-level assertions for the analog clock and buffer register bank
// Assumes: One pclk domain, presetn asynchronous active low
// Notes:   Selector checks wait until the code register has been quiet a while
`timescale 1ns/1ps
module acb_ctrl_chk (
  input logic                    pclk,
  input logic                    presetn,
  input acb_pkg::acb_variant_type variant,
  input logic                    psel,
  input logic                    penable,
  input logic                    pwrite,
  input logic [11:0]             paddr,
  input logic [31:0]             pwdata,
  input logic [31:0]             prdata,
  input logic                    pready,
  input logic                    pslverr,
  input logic                    clock_a_block_range,
  input logic                    clock_b_block_range,
  input logic [7:0]              blocks_lo,
  input logic [7:0]              blocks_hi,
  input logic                    analog_clock_a,
  input logic                    analog_clock_b,
  input logic                    sample_hold_off,
  input logic                    buffer_power_level
);
  import acb_pkg::*;
  logic       wr;
  logic       lim;
  logic [7:0] csh;
  logic [2:0] quiet;
  logic [2:0] code_a;
  logic [2:0] code_b;
  logic       sel_a;
  logic       sel_b;
  assign wr = psel && penable && pwrite && pready;
  assign lim = (variant == ACB_VAR_TWO_LM);
  assign code_a = lim ? {1'b0, csh[1:0]} : csh[2:0];
  assign code_b = lim ? {1'b0, csh[4:3]} : csh[5:3];
  assign sel_a = clock_a_block_range ? blocks_hi[code_a] : blocks_lo[code_a];
  assign sel_b = clock_b_block_range ? blocks_hi[code_b] : blocks_lo[code_b];
  // Mux pipeline only judged once a new code has fully flushed through
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csh   <= 8'h00;
      quiet <= 3'h0;
    end else if (wr && paddr == ACB_ADDR_CLK_SRC) begin
      csh   <= pwdata[7:0];
      quiet <= 3'h0;
    end else if (quiet != 3'h7) begin
      quiet <= quiet + 3'h1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rd_setup;
    psel && !penable && !pwrite;
  endsequence
  sequence rd_access;
    psel && penable && pready;
  endsequence
  pready_on_a: assert property ($past(presetn) |-> pready)
    else $error("pready low after reset");
  no_error_a: assert property (!pslverr)
    else $error("pslverr raised");
  read_upper_a: assert property (rd_setup ##1 rd_access |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  lim_reserved_a: assert property ((rd_setup and paddr == ACB_ADDR_BUF_CTL && lim)
    ##1 rd_access |-> prdata[6:0] == 7'h0) else $error("reserved buffer bits read set");
  hold_off_a: assert property (wr && paddr == ACB_ADDR_CLK_SRC && !lim
    |-> ##2 sample_hold_off == $past(pwdata[6], 2)) else $error("sample hold bit wrong");
  power_write_a: assert property (wr && paddr == ACB_ADDR_BUF_CTL && !lim
    |-> ##2 buffer_power_level == $past(pwdata[0], 2)) else $error("power level wrong");
  power_steady_a: assert property (!(wr && paddr == ACB_ADDR_BUF_CTL)
    |-> ##2 $stable(buffer_power_level)) else $error("power level moved without write");
  clock_a_sel_a: assert property (quiet == 3'h7 && $stable(clock_a_block_range)
    && $past(clock_a_block_range) == $past(clock_a_block_range, 2)
    |-> analog_clock_a == $past(sel_a, 2))
    else $error("clock a source wrong");
  clock_b_sel_a: assert property (quiet == 3'h7 && $stable(clock_b_block_range)
    && $past(clock_b_block_range) == $past(clock_b_block_range, 2)
    |-> analog_clock_b == $past(sel_b, 2)) else $error("clock b source wrong");
endmodule : acb_ctrl_chk
bind acb_ctrl acb_ctrl_chk u_chk (
  .pclk, .presetn, .variant, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .clock_a_block_range, .clock_b_block_range, .blocks_lo, .blocks_hi,
  .analog_clock_a, .analog_clock_b, .sample_hold_off, .buffer_power_level
);

// ==== tb/acb_ctrl_tb.sv ====
// Purpose: Self-checking bench for the analog clock and buffer register bank
// Assumes: APB slave answers within a few cycles
// Notes:   Every variant is run after its own reset
`timescale 1ns/1ps
module acb_ctrl_tb;
  import acb_pkg::*;
  logic            pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic            clock_a_block_range = 0, clock_b_block_range = 0;
  logic [11:0]     paddr = 12'h000;
  logic [31:0]     pwdata = 32'h0, prdata, rd;
  logic [7:0]      blocks_lo = 8'h00, blocks_hi = 8'h00;
  logic            pready, pslverr, analog_clock_a, analog_clock_b;
  logic [10:0]     outs;
  acb_variant_type variant = ACB_VAR_FOUR;
  acb_variant_type vt [4] = '{ACB_VAR_FOUR, ACB_VAR_TWO, ACB_VAR_TWO_LM, ACB_VAR_ONE};
  int              err_total = 0, n_compared = 0, c, b, cm, bm, ca, cb;
  acb_ctrl DUT (.pclk, .presetn, .variant, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .clock_a_block_range, .clock_b_block_range, .blocks_lo, .blocks_hi,
    .analog_clock_a, .analog_clock_b, .sample_hold_off(outs[10]),
    .column_one_input_steer(outs[9]), .column_two_input_steer(outs[8]),
    .col1_out_buffer_on(outs[7]), .col2_out_buffer_on(outs[6]), .col0_out_buffer_on(outs[5]),
    .col3_out_buffer_on(outs[4]), .amp_bypass(outs[3]), .buffer_power_level(outs[2]),
    .col0_drives_analog_ground(outs[1]), .col1_odd_pin_group(outs[0]));
  initial begin
    forever #2 pclk = ~pclk;
  end
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      err_total++;
      final_report();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk_outs();
    logic        one;
    logic [10:0] want;
    one = (variant == ACB_VAR_ONE);
    repeat (2) @(negedge pclk);
    want = {c[6], b[7] & ~one, b[6], b[5], b[4], b[3] & ~one, b[2], b[1], b[0], b[3] & one,
      b[7] & one};
    chk("outputs", want, outs);
  endtask : chk_outs
  initial begin
    void'($urandom(32'h6afd));
    foreach (vt[v]) begin
      @(posedge pclk);
      presetn <= 1'b0;
      variant <= vt[v];
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      cm = (vt[v] == ACB_VAR_TWO_LM) ? 8'h1b : 8'h7f;
      bm = (vt[v] == ACB_VAR_FOUR) ? 8'hff : (vt[v] == ACB_VAR_TWO) ? 8'hab
        : (vt[v] == ACB_VAR_TWO_LM) ? 8'h80 : 8'ha3;
      apb(1'b0, ACB_ADDR_CLK_SRC, 32'h0);
      chk("clk reset", 32'h0, rd);
      apb(1'b0, ACB_ADDR_BUF_CTL, 32'h0);
      chk("buf reset", 32'h0, rd);
      // All-ones on purpose: reserved places must not store
      apb(1'b1, ACB_ADDR_CLK_SRC, 32'hffffffff);
      apb(1'b1, ACB_ADDR_BUF_CTL, 32'hffffffff);
      apb(1'b1, 12'h000, 32'hffffffff);
      apb(1'b0, ACB_ADDR_CLK_SRC, 32'h0);
      chk("clk mask", cm, rd);
      apb(1'b0, ACB_ADDR_BUF_CTL, 32'h0);
      chk("buf mask", bm, rd);
      apb(1'b0, 12'h000, 32'h0);
      chk("unmapped", 32'h0, rd);
      for (int k = 0; k < 8; k++) begin
        c = (($urandom & 32'h40) | k | ((7 - k) << 3)) & cm;
        b = $urandom & bm;
        apb(1'b1, ACB_ADDR_CLK_SRC, c);
        apb(1'b1, ACB_ADDR_BUF_CTL, b);
        chk_outs();
        apb(1'b0, ACB_ADDR_BUF_CTL, 32'h0);
        chk("buf read", b, rd);
        @(posedge pclk);
        blocks_lo <= 8'($urandom);
        blocks_hi <= 8'($urandom);
        clock_a_block_range <= 1'($urandom);
        clock_b_block_range <= 1'($urandom);
        repeat (8) @(negedge pclk);
        ca = (vt[v] == ACB_VAR_TWO_LM) ? c & 3 : c & 7;
        cb = (vt[v] == ACB_VAR_TWO_LM) ? (c >> 3) & 3 : (c >> 3) & 7;
        ca = clock_a_block_range ? blocks_hi[ca] : blocks_lo[ca];
        cb = clock_b_block_range ? blocks_hi[cb] : blocks_lo[cb];
        chk("clock a", ca, analog_clock_a);
        chk("clock b", cb, analog_clock_b);
      end
    end
    final_report();
  end
endmodule : acb_ctrl_tb
